// File: hw/frm_flash_read.v
// read modes, identification space and security segments of a dual-bank flash
// Contract
// - command 90h at bank of address 0 enters identification mode
// - command FFh returns to array reading; host issues it before others
// - factory 64-bit segment at 81h-84h, locked by lock word bit 0
// - user segment 85h-88h programmable only while lock bit 1 unprogrammed
// - maker code at 0, part code at 1, read config at 5
// - block base plus 2 returns lock state bits 0 and 1
// - power-up defaults to asynchronous random reading
// - burst start address taken on clock edge with enables low
// - burst crosses bank boundary, wraps from upper end to lower bank
// - burst started in busy bank returns status, counter still advances
// - crossing into busy bank returns status until that bank ends
// - eight-word page, page_word_select gives random access in page
// - supply below lockout blocks program and erase, sets supply_fault_flag
// - chip_enable_n and hard_reset_n high: standby, outputs released
// - no input toggling enters auto_power_save, outputs keep last word; here entered only while chip_enable_n is low
// - reads allowed only after reset recovery delay following reset
// - continuous burst past last address wraps to zero
`timescale 1ns/10ps
`include "frm_consts.vh"
module frm_flash_read #(
  parameter ADDR_W = 21,
  parameter DATA_W = 16,
  parameter PAGE_W = 3,
  parameter [ADDR_W-1:0] BANK_SPLIT = 21'h080000,
  parameter BOOT_TOP = 1,
  parameter RECOVERY_CYCLES = (`FRM_RESET_RECOVERY_NS + `FRM_CLK_NS - 1) / `FRM_CLK_NS,
  parameter APS_CYCLES = `FRM_APS_IDLE_CYCLES
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire hard_reset_n,
  input wire chip_enable_n,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire address_valid_n,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out,
  output wire data_oe_n,
  input wire program_supply_ok,
  input wire core_supply_ok,
  input wire [1:0] bank_busy,
  input wire [7:0] busy_status,
  input wire [1:0] block_lock_bits,
  input wire [DATA_W-1:0] array_word,
  output wire [ADDR_W-1:0] array_addr,
  output reg supply_fault_flag,
  output reg auto_power_save,
  output wire standby,
  output wire read_ready
);
  // ----------------------------------------
  // states and locals
  // ----------------------------------------
  localparam [1:0] ST_ARRAY = 2'b00;
  localparam [1:0] ST_IDENT = 2'b01;
  localparam [1:0] ST_SEG_SETUP = 2'b10;
  localparam RC_W = 8;
  localparam AP_W = 8;
  localparam [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};
  localparam [63:0] USER_RESET = `FRM_USER_SEG_RESET;

  // ----------------------------------------
  // behaviour notes
  // ----------------------------------------
  // write_enable_n and address_valid_n are sampled on core_clk, a pulse shorter than a clock is missed
  // a write is taken on rising write_enable_n, holding it low issues nothing
  // the low data byte is the command, the high byte is ignored for commands
  // a setup command is always closed by the next write, whatever its address
  // identification mode is entered only through the bank holding address zero
  // array reading is restored by read array from any bank
  // segment programming only clears bits, like array cells
  // lock word bit 0 is fixed at zero, so the factory segment never changes
  // clearing lock word bit 1 seals the user segment for good
  // a segment write with a supply below lockout changes nothing, flags a fault
  // the fault flag stays set until the next read array command
  // bank busy flags and the status byte come from the program and erase engine
  // the read configuration word has no write path here, so sync mode stays off
  // the burst counter has no length limit and behaves as a continuous burst
  // a busy bank entered mid-burst shows status until its last word
  // wrapping past the top of the array returns to the first bank
  // page reads use the latched upper address with the low pins followed live
  // the identification decode ignores address bits above bit 7
  // part code follows the boot variant parameter
  // clk_en low freezes every register, the strobe history included
  // data_oe_n is combinational, so the bus is released in the same cycle
  // data_out is registered and shows a word one clock after the read starts
  // power save only stops data_out updates, counters keep running
  // reset recovery holds data_oe_n high, so no stale word reaches the bus

  // command and segment state
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [15:0] read_config_reg;
  reg [15:0] seg_lock_reg;
  reg we_n_d_reg;

  // address capture and burst state
  reg [ADDR_W-1:0] addr_latch_reg;
  reg [ADDR_W-1:0] burst_addr_reg;
  reg burst_busy_reg;

  // recovery and power save state
  reg [RC_W-1:0] recover_reg;
  reg [AP_W-1:0] idle_reg;
  reg [ADDR_W+4:0] last_inputs_reg;

  // decoded strobes, selects and read words
  wire [15:0] ident_word;
  wire sync_mode;
  wire write_strobe;
  wire [ADDR_W-1:0] read_addr;
  wire [ADDR_W+4:0] cur_inputs;
  wire read_active;
  wire cmd_bank0;
  wire seg_write;
  wire [7:0] seg_ofs;
  wire supply_good;
  wire user_open;
  wire [3:0] user_word_hit;
  wire [63:0] user_seg_bits;
  reg [DATA_W-1:0] word_sel;
  genvar gi;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // a write is taken on the rising edge of write_enable_n with the chip selected
  assign write_strobe = ~we_n_d_reg & write_enable_n & ~chip_enable_n & hard_reset_n;
  assign cmd_bank0 = addr < BANK_SPLIT; // address 0 always sits in the bank below the split
  assign sync_mode = read_config_reg[`FRM_CFG_SYNC_BIT];
  assign seg_write = write_strobe & (mode_reg == ST_SEG_SETUP);
  assign seg_ofs = addr[7:0];
  assign supply_good = program_supply_ok & core_supply_ok;
  assign user_open = seg_write & supply_good & seg_lock_reg[`FRM_LOCK_USER_BIT];

  // next mode from the command written, closed sequences return to array
  always @* begin
    mode_next = mode_reg;
    if (!hard_reset_n) begin
      mode_next = ST_ARRAY;
    end else if (write_strobe) begin
      case (mode_reg)
        ST_SEG_SETUP: mode_next = ST_ARRAY; // data word closes the sequence
        ST_ARRAY, ST_IDENT: begin
          if (data_in[7:0] == `FRM_CMD_IDENT && cmd_bank0)
            mode_next = ST_IDENT;
          else if (data_in[7:0] == `FRM_CMD_READ_ARRAY)
            mode_next = ST_ARRAY;
          else if (data_in[7:0] == `FRM_CMD_SEG_SETUP)
            mode_next = ST_SEG_SETUP;
          else
            mode_next = mode_reg;
        end
        default: mode_next = ST_ARRAY; // unused code falls back to array reading
      endcase
    end
  end

  // mode and write strobe history registers
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= ST_ARRAY;
      we_n_d_reg <= 1'b1;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      we_n_d_reg <= write_enable_n;
    end
  end

  // ----------------------------------------
  // security segments
  // ----------------------------------------
  // programming only clears bits; locked segments are refused
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_lock_reg <= `FRM_SEG_LOCK_RESET;
      supply_fault_flag <= 1'b0;
    end else if (clk_en) begin
      if (seg_write) begin
        if (!supply_good) begin
          supply_fault_flag <= 1'b1;
        end else if (seg_ofs == `FRM_OFS_SEG_LOCK) begin
          seg_lock_reg[`FRM_LOCK_USER_BIT] <= seg_lock_reg[`FRM_LOCK_USER_BIT]
            & data_in[`FRM_LOCK_USER_BIT];
        end
        // factory segment and locked user segment are left unchanged
      end else if (write_strobe && data_in[7:0] == `FRM_CMD_READ_ARRAY) begin
        supply_fault_flag <= 1'b0;
      end
    end
  end

  // user segment words, each opened only while the lock bit is unprogrammed
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_user_word
      localparam [31:0] WORD_SUM = `FRM_OFS_USER_FIRST + gi;
      localparam [7:0] WORD_OFS = WORD_SUM[7:0];
      reg [15:0] word_reg;
      assign user_word_hit[gi] = user_open && (seg_ofs == WORD_OFS);
      // word gi holds segment bits 16*gi+15 down to 16*gi
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          word_reg <= USER_RESET[16*gi +: 16];
        end else if (clk_en) begin
          if (user_word_hit[gi])
            word_reg <= word_reg & data_in;
        end
      end
      assign user_seg_bits[16*gi +: 16] = word_reg;
    end
  endgenerate

  // read configuration word, no write path, reset and hard_reset_n load the default
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_config_reg <= `FRM_READ_CFG_RESET;
    end else if (clk_en) begin
      if (!hard_reset_n)
        read_config_reg <= `FRM_READ_CFG_RESET;
    end
  end

  // ----------------------------------------
  // address capture and burst counter
  // ----------------------------------------
  // latch on clock with address_valid_n low, burst start on clock with both enables low
  // the latch stays open while address_valid_n is held low
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_latch_reg <= {ADDR_W{1'b0}};
      burst_addr_reg <= {ADDR_W{1'b0}};
      burst_busy_reg <= 1'b0;
    end else if (clk_en) begin
      if (!address_valid_n) begin
        addr_latch_reg <= addr;
      end
      if (sync_mode && !chip_enable_n && !address_valid_n) begin
        burst_addr_reg <= addr;
        burst_busy_reg <= bank_busy[addr >= BANK_SPLIT];
      end else if (sync_mode && !chip_enable_n) begin
        // counter advances every clock, wrapping past the last address to zero
        burst_addr_reg <= (burst_addr_reg == ADDR_LAST) ? {ADDR_W{1'b0}}
          : burst_addr_reg + 1'b1;
        if (burst_addr_reg == ADDR_LAST || burst_addr_reg + 1'b1 == BANK_SPLIT)
          burst_busy_reg <= bank_busy[burst_addr_reg != ADDR_LAST];
      end
    end
  end

  // page mode: upper address latched, page_word_select follows the pins
  assign read_addr = sync_mode ? burst_addr_reg
    : {addr_latch_reg[ADDR_W-1:PAGE_W], addr[PAGE_W-1:0]};
  // the array is addressed with the same word the output would show
  assign array_addr = read_addr;

  frm_ident_rom u_rom (
    .word_ofs(read_addr[7:0]),
    .boot_top(BOOT_TOP != 0),
    .block_lock(block_lock_bits),
    .read_config(read_config_reg),
    .seg_lock(seg_lock_reg),
    .user_seg(user_seg_bits),
    .word_out(ident_word)
  );

  // ----------------------------------------
  // reset recovery and power save
  // ----------------------------------------
  // reads are held off for the recovery delay after hard_reset_n rises
  // the delay is rounded up to whole clocks, so it is never shorter
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      recover_reg <= {RC_W{1'b0}};
    end else if (clk_en) begin
      if (!hard_reset_n)
        recover_reg <= RECOVERY_CYCLES[RC_W-1:0];
      else if (recover_reg != {RC_W{1'b0}})
        recover_reg <= recover_reg - 1'b1;
    end
  end
  // ready only once the pin is high and the count has run out
  assign read_ready = hard_reset_n & (recover_reg == {RC_W{1'b0}});

  // every pin that counts as activity for power save
  assign cur_inputs = {addr, chip_enable_n, output_enable_n, write_enable_n, address_valid_n, hard_reset_n};
  // idle counter enters power save when no input toggles while chip_enable_n is low
  // power save is left on the first toggle of any of these pins
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_reg <= {AP_W{1'b0}};
      last_inputs_reg <= {(ADDR_W+5){1'b0}};
      auto_power_save <= 1'b0;
    end else if (clk_en) begin
      last_inputs_reg <= cur_inputs;
      if (cur_inputs != last_inputs_reg) begin
        idle_reg <= {AP_W{1'b0}};
        auto_power_save <= 1'b0;
      end else if (idle_reg == APS_CYCLES[AP_W-1:0] - 1'b1) begin
        auto_power_save <= ~chip_enable_n;
      end else begin
        idle_reg <= idle_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // output data
  // ----------------------------------------
  // bus drive: standby releases the pins, reads drive them once recovered
  assign read_active = ~chip_enable_n & ~output_enable_n & read_ready;
  assign standby = chip_enable_n & hard_reset_n;
  assign data_oe_n = ~read_active;

  // word source: identification space, busy status or array
  always @* begin
    word_sel = array_word;
    if (mode_reg == ST_IDENT)
      word_sel = ident_word;
    else if (sync_mode && burst_busy_reg)
      word_sel = {8'h00, busy_status};
    else
      word_sel = array_word;
  end

  // output word register holds the last word while in power save
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= {DATA_W{1'b0}};
    end else if (clk_en) begin
      if (read_active && !auto_power_save)
        data_out <= word_sel;
    end
  end
endmodule

// File: hw/frm_consts.vh
// constants for the flash read-mode and protection register block
`ifndef FRM_CONSTS_VH
`define FRM_CONSTS_VH
// ----------------------------------------
// commands
// ----------------------------------------
`define FRM_CMD_IDENT 8'h90
`define FRM_CMD_READ_ARRAY 8'hFF
`define FRM_CMD_SEG_SETUP 8'hC0
`define FRM_CMD_ARRAY_SETUP 8'h40
// ----------------------------------------
// identification space word offsets
// ----------------------------------------
`define FRM_OFS_MAKER 8'h00
`define FRM_OFS_PART 8'h01
`define FRM_OFS_BLOCK_LOCK 8'h02
`define FRM_OFS_READ_CFG 8'h05
`define FRM_OFS_SEG_LOCK 8'h80
`define FRM_OFS_FACT_FIRST 8'h81
`define FRM_OFS_FACT_LAST 8'h84
`define FRM_OFS_USER_FIRST 8'h85
`define FRM_OFS_USER_LAST 8'h88
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define FRM_LOCK_FACT_BIT 0
`define FRM_LOCK_USER_BIT 1
`define FRM_SEG_LOCK_RESET 16'hFFFE
`define FRM_USER_SEG_RESET 64'hFFFFFFFFFFFFFFFF
`define FRM_RESERVED_WORD 16'h0000
`define FRM_READ_CFG_RESET 16'h0000
`define FRM_CFG_SYNC_BIT 15
// ----------------------------------------
// timing
// ----------------------------------------
`define FRM_CLK_NS 5
`define FRM_RESET_RECOVERY_NS 200
`define FRM_RESET_PULSE_NS 100
`define FRM_APS_IDLE_CYCLES 16
`endif

// File: hw/frm_ident_rom.v
// identification space word decoder for the flash read block
`timescale 1ns/10ps
module frm_ident_rom #(
  parameter [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
  parameter [15:0] PART_CODE_TOP = 16'h1234, // arbitrary value
  parameter [15:0] PART_CODE_BOTTOM = 16'h1235, // arbitrary value
  parameter [63:0] FACTORY_ID = 64'h0123456789ABCDEF // arbitrary value
) (
  input wire [7:0] word_ofs,
  input wire boot_top,
  input wire [1:0] block_lock,
  input wire [15:0] read_config,
  input wire [15:0] seg_lock,
  input wire [63:0] user_seg,
  output reg [15:0] word_out
);
  // ----------------------------------------
  // word select
  // ----------------------------------------
  // combinational decode of one identification word
  always @* begin
    word_out = `FRM_RESERVED_WORD;
    case (word_ofs)
      `FRM_OFS_MAKER: word_out = MAKER_CODE;
      `FRM_OFS_PART: word_out = boot_top ? PART_CODE_TOP : PART_CODE_BOTTOM;
      `FRM_OFS_BLOCK_LOCK: word_out = {14'h0, block_lock};
      `FRM_OFS_READ_CFG: word_out = read_config;
      `FRM_OFS_SEG_LOCK: word_out = seg_lock;
      8'h81: word_out = FACTORY_ID[15:0];
      8'h82: word_out = FACTORY_ID[31:16];
      8'h83: word_out = FACTORY_ID[47:32];
      8'h84: word_out = FACTORY_ID[63:48];
      8'h85: word_out = user_seg[15:0];
      8'h86: word_out = user_seg[31:16];
      8'h87: word_out = user_seg[47:32];
      8'h88: word_out = user_seg[63:48];
      default: word_out = `FRM_RESERVED_WORD;
    endcase
  end
endmodule

// File: bench/frm_flash_read_props.sv
// port checker for the flash read block
`timescale 1ns/10ps
module frm_flash_read_props #(
  parameter ADDR_W = 21,
  parameter DATA_W = 16,
  parameter RECOVERY_CYCLES = 40
) (
  input wire core_clk,
  input wire reset_n,
  input wire hard_reset_n,
  input wire chip_enable_n,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire [ADDR_W-1:0] addr,
  input wire program_supply_ok,
  input wire core_supply_ok,
  input wire [DATA_W-1:0] data_out,
  input wire data_oe_n,
  input wire supply_fault_flag,
  input wire auto_power_save,
  input wire standby,
  input wire read_ready
);
  localparam int REC_MAX = RECOVERY_CYCLES + 2;
  reg we_low_reg;
  reg [5:0] idle_reg;
  reg [ADDR_W+2:0] pins_reg;
  wire [ADDR_W+2:0] pins_now = {addr, chip_enable_n, output_enable_n, write_enable_n};
  wire wr_taken = we_low_reg && write_enable_n && !chip_enable_n;
  // strobe history and a count of cycles with no pin toggling while selected
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      we_low_reg <= 1'b0;
      pins_reg <= '0;
      idle_reg <= 6'h00;
    end else begin
      we_low_reg <= !write_enable_n;
      pins_reg <= pins_now;
      if (pins_now != pins_reg || chip_enable_n || !hard_reset_n) idle_reg <= 6'h00;
      else if (idle_reg != 6'h3F) idle_reg <= idle_reg + 6'h01;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence pin_release;
    $rose(hard_reset_n);
  endsequence
  sequence recovery_run;
    !read_ready ##[1:REC_MAX] read_ready;
  endsequence
  standby_out_a: assert property (chip_enable_n && hard_reset_n |-> standby && data_oe_n)
    else $error("outputs driven in standby");
  oe_gate_a: assert property (!data_oe_n |-> !chip_enable_n && !output_enable_n && read_ready)
    else $error("outputs driven without read enables");
  ready_wait_a: assert property (pin_release |-> recovery_run)
    else $error("read ready timing after pin reset");
  fault_hold_a: assert property (supply_fault_flag && !wr_taken |=> supply_fault_flag)
    else $error("fault flag dropped without a write");
  fault_cause_a: assert property ($rose(supply_fault_flag) |-> !$past(program_supply_ok) || !$past(core_supply_ok))
    else $error("fault flag set with good supplies");
  aps_enter_a: assert property (idle_reg == 6'h28 |-> auto_power_save)
    else $error("power save not entered when idle");
  aps_hold_a: assert property (auto_power_save && $past(auto_power_save) |-> $stable(data_out))
    else $error("data changed in power save");
  idle_data_a: assert property (chip_enable_n && $past(chip_enable_n) |-> $stable(data_out))
    else $error("data changed while deselected");
endmodule
bind frm_flash_read frm_flash_read_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RECOVERY_CYCLES(RECOVERY_CYCLES))
  i_frm_flash_read_props (.core_clk(core_clk), .reset_n(reset_n), .hard_reset_n(hard_reset_n),
  .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .addr(addr), .program_supply_ok(program_supply_ok), .core_supply_ok(core_supply_ok), .data_out(data_out),
  .data_oe_n(data_oe_n), .supply_fault_flag(supply_fault_flag), .auto_power_save(auto_power_save),
  .standby(standby), .read_ready(read_ready));

// File: bench/frm_host_model.sv
// host bus model driving the flash read block pins
`timescale 1ns/10ps
module frm_host_model (
  input wire core_clk,
  input wire [15:0] data_out,
  output reg hard_reset_n,
  output reg chip_enable_n,
  output reg output_enable_n,
  output reg write_enable_n,
  output reg address_valid_n,
  output reg [20:0] addr,
  output reg [15:0] data_in
);
  // pins idle at time zero, bus lines parked on a pattern
  initial begin
    {hard_reset_n, chip_enable_n, output_enable_n, write_enable_n, address_valid_n} = 5'h1F;
    addr = 21'h0A5A5A;
    data_in = 16'hA5A5;
  end
  task automatic step;
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  // write strobe rises under chip enable, then the bus is parked inverted
  task automatic bus_write(input [20:0] a, input [15:0] d);
    begin
      step;
      addr = a;
      data_in = d;
      {chip_enable_n, write_enable_n} = 2'b00;
      step;
      write_enable_n = 1'b1;
      step;
      chip_enable_n = 1'b1;
      addr = ~a;
      data_in = ~d;
    end
  endtask
  // address latched by a valid pulse, then both enables low and held
  task automatic bus_read(input [20:0] a, output [15:0] d);
    begin
      step;
      addr = a;
      address_valid_n = 1'b0;
      step;
      {address_valid_n, chip_enable_n, output_enable_n} = 3'b100;
      repeat (3) step;
      d = data_out;
    end
  endtask
  // word select moves inside the page while chip enable stays low
  task automatic page_read(input [2:0] w, output [15:0] d);
    begin
      step;
      addr[2:0] = w;
      repeat (3) step;
      d = data_out;
    end
  endtask
  task automatic bus_park;
    begin
      step;
      {chip_enable_n, output_enable_n} = 2'b11;
      addr = ~addr;
    end
  endtask
  // reset pin held low for a number of cycles, shortened for simulation
  task automatic pin_reset(input integer n);
    begin
      step;
      hard_reset_n = 1'b0;
      repeat (n) step;
      hard_reset_n = 1'b1;
    end
  endtask
endmodule

// File: bench/frm_flash_read_test.sv
// self-checking bench for the flash read block
`timescale 1ns/10ps
`include "frm_consts.vh"
module frm_flash_read_test;
  localparam [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam [15:0] PART_BOT = 16'h1235; // arbitrary value
  reg core_clk, reset_n, program_supply_ok, core_supply_ok;
  reg [1:0] block_lock_bits;
  reg clk_en;
  reg [1:0] bank_busy;
  reg [7:0] busy_status;
  reg [15:0] rd;
  integer fails, cmp_count, k;
  wire hard_reset_n, chip_enable_n, output_enable_n, write_enable_n, address_valid_n;
  wire data_oe_n, supply_fault_flag, auto_power_save, standby, read_ready;
  wire [20:0] addr, array_addr;
  wire [15:0] data_in, data_out;
  wire [15:0] array_word = array_addr[15:0] ^ 16'h5A5A;
  frm_host_model i_frm_host_model (.core_clk(core_clk), .data_out(data_out), .hard_reset_n(hard_reset_n),
    .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .address_valid_n(address_valid_n), .addr(addr), .data_in(data_in));
  frm_flash_read #(.BOOT_TOP(0), .RECOVERY_CYCLES(4)) i_frm_flash_read (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .hard_reset_n(hard_reset_n), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .address_valid_n(address_valid_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .program_supply_ok(program_supply_ok),
    .core_supply_ok(core_supply_ok), .bank_busy(bank_busy), .busy_status(busy_status), .block_lock_bits(block_lock_bits),
    .array_word(array_word), .array_addr(array_addr), .supply_fault_flag(supply_fault_flag),
    .auto_power_save(auto_power_save), .standby(standby), .read_ready(read_ready));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task automatic chk_word(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic chk_bit(input got, input exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
    end
  endtask
  task automatic cmd(input [20:0] a, input [7:0] c);
    i_frm_host_model.bus_write(a, {8'h00, c});
  endtask
  // enter identification space and read one word
  task automatic ident_chk(input [20:0] a, input [15:0] exp);
    begin
      cmd(21'h0, `FRM_CMD_IDENT);
      i_frm_host_model.bus_read(a, rd);
      i_frm_host_model.bus_park;
      chk_word(rd, exp);
    end
  endtask
  task automatic seg_prog(input [20:0] a, input [15:0] d);
    begin
      cmd(a, `FRM_CMD_SEG_SETUP);
      i_frm_host_model.bus_write(a, d);
      cmd(21'h0, `FRM_CMD_READ_ARRAY);
    end
  endtask
  task automatic test_ident;
    begin
      ident_chk(21'h0, MAKER);
      ident_chk(21'h1, PART_BOT);
      ident_chk(21'h5, 16'h0000);
      ident_chk(21'h3, 16'h0000);
      ident_chk(21'h80, 16'hFFFE);
      ident_chk(21'h81, 16'hCDEF);
      for (k = 0; k < 4; k = k + 1) begin
        block_lock_bits = k[1:0];
        ident_chk(21'h08002, {14'h0, k[1:0]});
      end
      cmd(21'h0, `FRM_CMD_READ_ARRAY);
      i_frm_host_model.bus_read(21'h40, rd);
      i_frm_host_model.bus_park;
      chk_word(rd, 16'h0040 ^ 16'h5A5A);
    end
  endtask
  task automatic test_segments;
    begin
      seg_prog(21'h85, 16'h1234);
      ident_chk(21'h85, 16'h1234);
      seg_prog(21'h81, 16'h0000);
      ident_chk(21'h81, 16'hCDEF);
      seg_prog(21'h80, 16'hFFFD);
      ident_chk(21'h80, 16'hFFFC);
      seg_prog(21'h86, 16'h0000);
      ident_chk(21'h86, 16'hFFFF);
    end
  endtask
  // each supply in turn below lockout during a segment write
  task automatic test_supply;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        {program_supply_ok, core_supply_ok} = k ? 2'b10 : 2'b01;
        cmd(21'h87, `FRM_CMD_SEG_SETUP);
        i_frm_host_model.bus_write(21'h87, 16'h0000);
        chk_bit(supply_fault_flag, 1'b1);
        {program_supply_ok, core_supply_ok} = 2'b11;
        cmd(21'h0, `FRM_CMD_READ_ARRAY);
        chk_bit(supply_fault_flag, 1'b0);
      end
      ident_chk(21'h87, 16'hFFFF);
    end
  endtask
  task automatic test_page;
    begin
      cmd(21'h0, `FRM_CMD_READ_ARRAY);
      i_frm_host_model.bus_read(21'h00120, rd);
      chk_word(rd, 16'h0120 ^ 16'h5A5A);
      for (k = 7; k > 0; k = k - 1) begin
        i_frm_host_model.page_read(k[2:0], rd);
        chk_word(rd, {13'h0024, k[2:0]} ^ 16'h5A5A);
      end
      repeat (45) i_frm_host_model.step;
      chk_bit(auto_power_save, 1'b1);
      chk_word(data_out, rd);
      i_frm_host_model.bus_park;
      i_frm_host_model.step;
      chk_bit(standby, 1'b1);
      chk_bit(data_oe_n, 1'b1);
    end
  endtask
  // reset pin in identification mode, reads held off then array returns
  task automatic test_pin;
    begin
      cmd(21'h0, `FRM_CMD_IDENT);
      i_frm_host_model.pin_reset(3);
      chk_bit(read_ready, 1'b0);
      k = 0;
      while (read_ready !== 1'b1 && k < 20) begin
        i_frm_host_model.step;
        k = k + 1;
      end
      if (read_ready !== 1'b1) begin
        fails = fails + 1;
        $display("[ERR] %0t ready wait ran out", $time);
        stop_test;
      end
      i_frm_host_model.bus_read(21'h44, rd);
      i_frm_host_model.bus_park;
      chk_word(rd, 16'h0044 ^ 16'h5A5A);
    end
  endtask
  // a command written while clk_en is low is not taken
  task automatic test_freeze;
    begin
      clk_en = 1'b0;
      cmd(21'h0, `FRM_CMD_IDENT);
      clk_en = 1'b1;
      i_frm_host_model.bus_read(21'h50, rd);
      i_frm_host_model.bus_park;
      chk_word(rd, 16'h0050 ^ 16'h5A5A);
    end
  endtask
  initial begin
    {reset_n, program_supply_ok, core_supply_ok} = 3'b011;
    block_lock_bits = 2'b00;
    clk_en = 1'b1;
    bank_busy = 2'b00;
    busy_status = 8'h00;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    test_ident;
    test_segments;
    test_supply;
    test_page;
    test_pin;
    test_freeze;
    stop_test;
  end
endmodule
